/* logic/efr_regulator.sv */
// Encoder feedback regulator: mismatch monitor, PID velocity regulator and closed-loop angle.
//
// Functional notes
// - Fail flag set when deviation exceeds tolerance.
// - Fail event fires as fail flag sets.
// - Regulating: target reached needs deviation within tolerance.
// - Error is internal minus encoder; stop within tolerance.
// - Velocity is P, I and D terms summed.
// - Integrator updates at clock divided by 128.
// - Velocity, integrator sum and error are readable.
// - Velocity and readout clipped to deviation clip.
// - Integrator sum limited to integrator clip field.
// - Unclipped integrator keeps growing while motor lags.
// - Derivative time base scaled by clock divider.
// - Mode 11 outputs ramp velocity plus regulator.
// - Mode 10 outputs regulator velocity alone.
// - Hysteresis band suppresses correction near position.
// - Loop offset readable and writable by software.
// - Deviation is internal minus encoder minus offset.
// - Angle clamps at maximum, raising angle event.
// - Fit flag within tolerance; event on recovery.
// - Gain 1.0 within tolerance, else scaled correction.
// - Loop gain has 16 fractional bits.
// - Cycle delay programmed or five for incremental.
// - Mode 01 enables closed-loop commutation.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "efr_map.svh"
module efr_regulator
    import efr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [6:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic signed [31:0] internal_position,
    input wire logic signed [31:0] target_position,
    input wire logic signed [31:0] encoder_position,
    input wire logic signed [31:0] ramp_velocity,
    output logic signed [31:0] regulated_velocity,
    output logic signed [31:0] commutation_angle,
    output logic mismatch_fail_flag,
    output logic mismatch_fail_event,
    output logic target_reached_flag,
    output logic target_reached_event,
    output logic loop_fit_flag,
    output logic loop_fit_event,
    output logic angle_limit_event
);
    // ======================================================================
    // Configuration registers
    logic [31:0] cfg_q, beta_q, tr_tol_q, fail_tol_q, offset_q, clgain_q;
    logic [31:0] clip_q, dvclip_q, hyst_q, cycle_q, pgain_q, igain_q, dgain_q;
    efr_mode_t mode;

    assign mode = efr_mode_t'(cfg_q[`EFR_F_MODE]);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cfg_q <= `EFR_RST_WORD;
            beta_q <= `EFR_RST_WORD;
            tr_tol_q <= `EFR_RST_WORD;
            fail_tol_q <= `EFR_RST_WORD;
            offset_q <= `EFR_RST_WORD;
            clgain_q <= `EFR_RST_WORD;
            clip_q <= `EFR_RST_WORD;
            dvclip_q <= `EFR_RST_WORD;
            hyst_q <= `EFR_RST_WORD;
            cycle_q <= `EFR_RST_WORD;
            pgain_q <= `EFR_RST_WORD;
            igain_q <= `EFR_RST_WORD;
            dgain_q <= `EFR_RST_WORD;
        end else if (reg_wr) begin
            case (reg_addr)
                `EFR_A_ENC_CFG: cfg_q <= reg_wdata;
                `EFR_A_BETA: beta_q <= {23'h0, reg_wdata[`EFR_F_BETA]};
                `EFR_A_DEV: tr_tol_q <= reg_wdata;
                `EFR_A_DEV_TOL: fail_tol_q <= reg_wdata;
                `EFR_A_OFFSET: offset_q <= reg_wdata;
                `EFR_A_CLGAIN: clgain_q <= {8'h0, reg_wdata[`EFR_F_CLGAIN]};
                `EFR_A_ERR: clip_q <= reg_wdata;
                `EFR_A_DVCLIP: dvclip_q <= reg_wdata;
                `EFR_A_HYST: hyst_q <= reg_wdata;
                `EFR_A_CYCLE: cycle_q <= reg_wdata;
                `EFR_A_PGAIN: pgain_q <= {16'h0, reg_wdata[`EFR_F_GAIN]};
                `EFR_A_IGAIN: igain_q <= {16'h0, reg_wdata[`EFR_F_GAIN]};
                `EFR_A_DGAIN: dgain_q <= {16'h0, reg_wdata[`EFR_F_GAIN]};
                default: cfg_q <= cfg_q;
            endcase
        end
    end

    // ======================================================================
    // Position deviation and mismatch monitor
    logic signed [33:0] dev_raw;
    logic signed [31:0] dev_c, dev_q;
    logic [31:0] abs_dev, fit_tol;
    logic fail_c, fit_c, tr_c;

    assign dev_raw = 34'(internal_position) - 34'(encoder_position) - 34'($signed(offset_q));

    efr_sat #(.IW(34)) u_dev_sat (
        .din(dev_raw),
        .lim(`EFR_NO_LIMIT),
        .dout(dev_c)
    );

    assign abs_dev = dev_q[31] ? 32'(-dev_q) : dev_q;
    assign fit_tol = {24'h0, hyst_q[`EFR_F_FITTOL]};
    assign fail_c = abs_dev > fail_tol_q;
    assign fit_c = abs_dev <= fit_tol;
    assign tr_c = (internal_position == target_position) && ((mode == EFR_MODE_OFF) || (abs_dev <= tr_tol_q));

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            dev_q <= '0;
            mismatch_fail_flag <= 1'b0;
            mismatch_fail_event <= 1'b0;
            target_reached_flag <= 1'b0;
            target_reached_event <= 1'b0;
            loop_fit_flag <= 1'b0;
            loop_fit_event <= 1'b0;
        end else begin
            dev_q <= dev_c;
            mismatch_fail_flag <= fail_c;
            mismatch_fail_event <= fail_c && !mismatch_fail_flag;
            target_reached_flag <= tr_c;
            target_reached_event <= tr_c && !target_reached_flag;
            loop_fit_flag <= fit_c;
            loop_fit_event <= fit_c && !loop_fit_flag;
        end
    end

    // ======================================================================
    // PID error, integrator and derivative
    logic signed [31:0] err_c, err_q, isum_c, isum_q, e_last_q;
    logic signed [32:0] delta_q;
    logic signed [33:0] isum_raw;
    logic [31:0] abs_err;
    logic [7:0] dcnt_q;
    logic isum_tick;

    efr_sat #(.IW(33)) u_err_sat (
        .din(33'(internal_position) - 33'(encoder_position)),
        .lim(`EFR_NO_LIMIT),
        .dout(err_c)
    );

    efr_div #(.W(16)) u_isum_div (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .period(`EFR_ISUM_DIV),
        .tick(isum_tick)
    );

    assign isum_raw = 34'(isum_q) + 34'(err_q);

    efr_sat #(.IW(34)) u_isum_sat (
        .din(isum_raw),
        .lim({17'h0, clip_q[`EFR_F_ICLIP]}),
        .dout(isum_c)
    );

    assign abs_err = err_q[31] ? 32'(-err_q) : err_q;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            err_q <= '0;
        end else begin
            err_q <= err_c;
        end
    end

    // The sum only moves while a PID mode is selected, so it starts from zero on entry.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            isum_q <= '0;
        end else if (!mode[1]) begin
            isum_q <= '0;
        end else if (isum_tick) begin
            isum_q <= isum_c;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            dcnt_q <= '0;
            e_last_q <= '0;
            delta_q <= '0;
        end else if (isum_tick) begin
            if (dcnt_q >= clip_q[`EFR_F_DCLKDIV]) begin
                dcnt_q <= '0;
                e_last_q <= err_q;
                delta_q <= 33'(err_q) - 33'(e_last_q);
            end else begin
                dcnt_q <= dcnt_q + 8'h01;
            end
        end
    end

    // ======================================================================
    // Regulator velocity and output velocity
    logic signed [63:0] p_term, i_term, d_term, vpid_raw;
    logic signed [31:0] vpid_c, out_c, vel_q;
    logic hold_c;

    assign p_term = ($signed(64'(pgain_q)) * 64'(err_q)) >>> `EFR_PID_SHIFT;
    assign i_term = ($signed(64'(igain_q)) * 64'(isum_q)) >>> `EFR_PID_SHIFT;
    assign d_term = $signed(64'(dgain_q)) * 64'(delta_q);
    assign hold_c = 33'(abs_err) <= 33'(hyst_q);
    assign vpid_raw = hold_c ? 64'sh0 : p_term + i_term + d_term;

    efr_sat #(.IW(64)) u_vel_sat (
        .din(vpid_raw),
        .lim(dvclip_q),
        .dout(vpid_c)
    );

    efr_sat #(.IW(33)) u_out_sat (
        .din(33'(ramp_velocity) + 33'(vpid_c)),
        .lim(`EFR_NO_LIMIT),
        .dout(out_c)
    );

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            vel_q <= '0;
            regulated_velocity <= '0;
        end else begin
            vel_q <= vpid_c;
            case (mode)
                EFR_MODE_PIDV: regulated_velocity <= out_c;
                EFR_MODE_PID0: regulated_velocity <= vpid_c;
                default: regulated_velocity <= ramp_velocity;
            endcase
        end
    end

    // ======================================================================
    // Closed-loop commutation angle
    efr_rstate_t rs_q;
    logic signed [63:0] corr_raw;
    logic signed [31:0] corr_c, beta_s;
    logic [15:0] cyc_period;
    logic reg_tick, clamp_c, clamp_q;

    assign cyc_period = cfg_q[`EFR_F_ABS_ENC] ? cycle_q[`EFR_F_CYCLE] : `EFR_INC_CYCLE;

    efr_div #(.W(16)) u_cyc_div (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .period(cyc_period),
        .tick(reg_tick)
    );

    assign corr_raw = (64'(dev_q) * $signed(64'(clgain_q))) >>> `EFR_CL_FRAC;
    assign beta_s = $signed(beta_q);

    efr_sat #(.IW(64)) u_corr_sat (
        .din(corr_raw),
        .lim(beta_q),
        .dout(corr_c)
    );

    assign clamp_c = !fit_c && ((corr_c == beta_s) || (corr_c == -beta_s));

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rs_q <= EFR_RS_OFF;
        end else begin
            case (rs_q)
                EFR_RS_OFF: rs_q <= (mode == EFR_MODE_CL) ? EFR_RS_RUN : EFR_RS_OFF;
                EFR_RS_RUN: begin
                    if (mode != EFR_MODE_CL) begin
                        rs_q <= EFR_RS_OFF;
                    end else if (reg_tick) begin
                        rs_q <= EFR_RS_UPD;
                    end
                end
                EFR_RS_UPD: rs_q <= EFR_RS_RUN;
                default: rs_q <= EFR_RS_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            commutation_angle <= '0;
            clamp_q <= 1'b0;
            angle_limit_event <= 1'b0;
        end else if (rs_q == EFR_RS_UPD) begin
            // Inside the fit band the gain is 1.0, so the raw deviation is used.
            commutation_angle <= fit_c ? 32'(encoder_position + dev_q) : 32'(encoder_position + corr_c);
            clamp_q <= clamp_c;
            angle_limit_event <= clamp_c && !clamp_q;
        end else begin
            angle_limit_event <= 1'b0;
        end
    end

    // ======================================================================
    // Register read port
    logic [31:0] rd_c;

    always_comb begin
        case (reg_addr)
            `EFR_A_ENC_CFG: rd_c = cfg_q;
            `EFR_A_DEV: rd_c = dev_q;
            `EFR_A_OFFSET: rd_c = offset_q;
            `EFR_A_VEL: rd_c = vel_q;
            `EFR_A_ISUM: rd_c = isum_q;
            `EFR_A_ERR: rd_c = err_q;
            `EFR_A_PGAIN: rd_c = pgain_q;
            `EFR_A_IGAIN: rd_c = igain_q;
            `EFR_A_DGAIN: rd_c = dgain_q;
            `EFR_A_STATUS: rd_c = {26'h0, 2'(rs_q), clamp_q, loop_fit_flag, target_reached_flag, mismatch_fail_flag};
            default: rd_c = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_c : 32'h0000_0000;
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_fail_flag_set: assert property (fail_c |=> mismatch_fail_flag)
        else $error("fail flag not set on excess deviation");
    a_fail_event_edge: assert property (mismatch_fail_event |-> mismatch_fail_flag && !$past(mismatch_fail_flag))
        else $error("fail event not at flag rise");
    a_target_gate: assert property (target_reached_flag && $past(mode) != EFR_MODE_OFF |-> $past(abs_dev <= tr_tol_q))
        else $error("target reached with deviation out of tolerance");
    a_isum_clip: assert property (isum_tick |=> isum_q <= $signed({17'h0, $past(clip_q[`EFR_F_ICLIP])})
        && isum_q >= -$signed({17'h0, $past(clip_q[`EFR_F_ICLIP])}))
        else $error("integrator sum beyond clip");
    a_isum_rate: assert property ($changed(isum_q) |-> $past(isum_tick) || !$past(mode[1]))
        else $error("integrator moved off its tick");
    a_hyst_hold: assert property (hold_c |=> vel_q == 0)
        else $error("velocity not zero inside hysteresis");
    a_vel_clip: assert property ($stable(dvclip_q) |-> vel_q <= $signed({1'b0, dvclip_q[30:0]})
        && vel_q >= -$signed({1'b0, dvclip_q[30:0]}))
        else $error("velocity beyond deviation clip");
    a_mode_zero_base: assert property (mode == EFR_MODE_PID0 && $past(mode) == EFR_MODE_PID0
        |-> regulated_velocity == vel_q)
        else $error("mode 10 output differs from regulator velocity");
    a_fit_flag: assert property (fit_c |=> loop_fit_flag && (loop_fit_event == !$past(loop_fit_flag)))
        else $error("fit flag or event wrong");
    a_angle_event: assert property (angle_limit_event |-> clamp_q && $past(rs_q) == EFR_RS_UPD)
        else $error("angle event without clamp");
endmodule : efr_regulator

/* logic/efr_map.svh */
// Register offsets, field positions, reset values and timing counts of the feedback regulator.
`ifndef EFR_MAP_SVH
`define EFR_MAP_SVH

// ==========================================================================
// Register indices
`define EFR_A_ENC_CFG 7'h07
`define EFR_A_BETA 7'h1c
`define EFR_A_DEV 7'h52
`define EFR_A_DEV_TOL 7'h53
`define EFR_A_OFFSET 7'h59
`define EFR_A_VEL 7'h5a
`define EFR_A_ISUM 7'h5b
`define EFR_A_CLGAIN 7'h5c
`define EFR_A_ERR 7'h5d
`define EFR_A_DVCLIP 7'h5e
`define EFR_A_HYST 7'h5f
`define EFR_A_CYCLE 7'h63
`define EFR_A_PGAIN 7'h70
`define EFR_A_IGAIN 7'h71
`define EFR_A_DGAIN 7'h72
`define EFR_A_STATUS 7'h73

// ==========================================================================
// Field positions
`define EFR_F_MODE 1:0
`define EFR_F_ABS_ENC 2
`define EFR_F_ICLIP 14:0
`define EFR_F_DCLKDIV 23:16
`define EFR_F_BETA 8:0
`define EFR_F_FITTOL 7:0
`define EFR_F_CYCLE 31:16
`define EFR_F_CLGAIN 23:0
`define EFR_F_GAIN 15:0

// ==========================================================================
// Reset values and timing
`define EFR_RST_WORD 32'h0000_0000
`define EFR_ISUM_DIV 16'h0080
`define EFR_INC_CYCLE 16'h0005
`define EFR_PID_SHIFT 8
`define EFR_CL_FRAC 16
`define EFR_NO_LIMIT 32'h7fff_ffff

`endif

/* logic/efr_pkg.sv */
// Types shared by the feedback regulator modules.
package efr_pkg;
    typedef enum logic [1:0] {
        EFR_MODE_OFF = 2'b00,
        EFR_MODE_CL = 2'b01,
        EFR_MODE_PID0 = 2'b10,
        EFR_MODE_PIDV = 2'b11
    } efr_mode_t;

    typedef enum logic [1:0] {
        EFR_RS_OFF = 2'b00,
        EFR_RS_RUN = 2'b01,
        EFR_RS_UPD = 2'b11
    } efr_rstate_t;
endpackage : efr_pkg

/* logic/efr_sat.sv */
// Symmetric saturation of a wide signed value to a 32-bit signed result.
`timescale 1ns/1ps
module efr_sat #(
    parameter int IW = 64
) (
    input wire logic signed [IW-1:0] din,
    input wire logic [31:0] lim,
    output logic signed [31:0] dout
);
    logic signed [IW-1:0] lim_x;

    // The limit is taken as a non-negative 31-bit magnitude.
    assign lim_x = {{(IW-31){1'b0}}, lim[30:0]};

    always_comb begin
        if (din > lim_x) begin
            dout = lim_x[31:0];
        end else if (din < -lim_x) begin
            dout = 32'(-lim_x);
        end else begin
            dout = din[31:0];
        end
    end
endmodule : efr_sat

/* logic/efr_div.sv */
// Free-running tick divider with a programmable period.
`timescale 1ns/1ps
module efr_div #(
    parameter int W = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [W-1:0] period,
    output logic tick
);
    logic [W-1:0] cnt_q;

    // A period of zero behaves as a period of one.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (cnt_q + W'(1) >= period) begin
            cnt_q <= '0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + W'(1);
            tick <= 1'b0;
        end
    end
endmodule : efr_div

/* bench/efr_enc_model.sv */
// Behavioural encoder and step driver model that reports the shaft position behind the internal position.
`timescale 1ns/1ps
module efr_enc_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic signed [31:0] internal_position,
    input wire logic signed [31:0] slip,
    output logic signed [31:0] encoder_position
);
    // ==========================================================================
    // Shaft position
    // The shaft lags the commanded position by the slip that the bench imposes, one sample late like a real encoder.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            encoder_position <= 32'sh0000_0000;
        end else begin
            encoder_position <= internal_position - slip;
        end
    end
endmodule : efr_enc_model

/* bench/test_encoder_feedback_regulator.sv */
// Self-checking testbench of the encoder feedback regulator.
`timescale 1ns/1ps
`include "efr_map.svh"
module test_encoder_feedback_regulator;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic signed [31:0] internal_position = 32'sh0000_03e8;
    logic signed [31:0] target_position = 32'sh0000_03e8;
    logic signed [31:0] encoder_position;
    logic signed [31:0] ramp_velocity = 32'sh0;
    logic signed [31:0] slip = 32'sh0;
    logic signed [31:0] regulated_velocity;
    logic signed [31:0] commutation_angle;
    logic mismatch_fail_flag, mismatch_fail_event, target_reached_flag, target_reached_event;
    logic loop_fit_flag, loop_fit_event, angle_limit_event;
    int n_fail = 0;
    int samples_checked = 0;
    int cnt_fail = 0, cnt_tr = 0, cnt_fit = 0, cnt_lim = 0;
    int c0;
    logic [31:0] isum_a, isum_b;

    efr_regulator dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .internal_position(internal_position), .target_position(target_position),
        .encoder_position(encoder_position), .ramp_velocity(ramp_velocity),
        .regulated_velocity(regulated_velocity), .commutation_angle(commutation_angle),
        .mismatch_fail_flag(mismatch_fail_flag), .mismatch_fail_event(mismatch_fail_event),
        .target_reached_flag(target_reached_flag), .target_reached_event(target_reached_event),
        .loop_fit_flag(loop_fit_flag), .loop_fit_event(loop_fit_event), .angle_limit_event(angle_limit_event)
    );

    efr_enc_model enc_u (
        .ref_clk(ref_clk), .resetn(resetn), .internal_position(internal_position),
        .slip(slip), .encoder_position(encoder_position)
    );

    // ==========================================================================
    // Clock, event counters and watchdog
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (mismatch_fail_event === 1'b1) cnt_fail++;
        if (target_reached_event === 1'b1) cnt_tr++;
        if (loop_fit_event === 1'b1) cnt_fit++;
        if (angle_limit_event === 1'b1) cnt_lim++;
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        final_report();
    end

    // ==========================================================================
    // Tasks
    task automatic final_report();
        $display("checked=%0d failed=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask : chk_b

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk_w(d, exp);
    endtask : rd_chk

    task automatic set_slip(input logic signed [31:0] s, input int n);
        @(posedge ref_clk);
        slip <= s;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : set_slip

    // ==========================================================================
    // Main sequence; internal and target positions both sit at 1000.
    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        // The encoder model leaves reset with the regulator but registers the position one edge late, so the deviation settles before the first read.
        repeat (2) @(posedge ref_clk);
        rd_chk(`EFR_A_DEV, 32'h0);
        rd_chk(7'h10, 32'h0);
        rd_chk(`EFR_A_DEV_TOL, 32'h0);
        chk_b(mismatch_fail_flag, 1'b0);
        wr(`EFR_A_OFFSET, 32'h0000_0003);
        rd_chk(`EFR_A_OFFSET, 32'h0000_0003);
        set_slip(8, 6);
        rd_chk(`EFR_A_DEV, 32'h0000_0005);
        wr(`EFR_A_OFFSET, 32'h0);
        // Mismatch monitor at the tolerance boundary, both signs.
        wr(`EFR_A_DEV_TOL, 32'h0000_000a);
        set_slip(10, 6);
        chk_b(mismatch_fail_flag, 1'b0);
        c0 = cnt_fail;
        set_slip(11, 6);
        chk_b(mismatch_fail_flag, 1'b1);
        chk_w(cnt_fail - c0, 1);
        set_slip(-11, 6);
        chk_b(mismatch_fail_flag, 1'b1);
        set_slip(-10, 6);
        chk_b(mismatch_fail_flag, 1'b0);
        // Fit flag and recovery event.
        wr(`EFR_A_HYST, 32'h0000_0005);
        set_slip(20, 6);
        chk_b(loop_fit_flag, 1'b0);
        c0 = cnt_fit;
        set_slip(5, 6);
        chk_b(loop_fit_flag, 1'b1);
        chk_w(cnt_fit - c0, 1);
        set_slip(6, 6);
        chk_b(loop_fit_flag, 1'b0);
        // Target reached during regulation needs the deviation within its tolerance.
        wr(`EFR_A_DEV, 32'h0000_0004);
        wr(`EFR_A_ENC_CFG, 32'h0000_0002);
        set_slip(5, 6);
        chk_b(target_reached_flag, 1'b0);
        c0 = cnt_tr;
        set_slip(4, 6);
        chk_b(target_reached_flag, 1'b1);
        chk_w(cnt_tr - c0, 1);
        // Proportional path, base velocity choice, hysteresis and clipping.
        wr(`EFR_A_PGAIN, 32'h0000_0200);
        wr(`EFR_A_DVCLIP, 32'h7fff_ffff);
        wr(`EFR_A_HYST, 32'h0);
        ramp_velocity <= 32'sh0000_0064;
        set_slip(10, 6);
        rd_chk(`EFR_A_ERR, 32'h0000_000a);
        rd_chk(`EFR_A_VEL, 32'h0000_0014);
        chk_w(regulated_velocity, 32'h0000_0014);
        wr(`EFR_A_ENC_CFG, 32'h0000_0003);
        set_slip(10, 6);
        chk_w(regulated_velocity, 32'h0000_0078);
        wr(`EFR_A_ENC_CFG, 32'h0000_0002);
        wr(`EFR_A_HYST, 32'h0000_0014);
        set_slip(10, 6);
        rd_chk(`EFR_A_VEL, 32'h0);
        set_slip(25, 6);
        rd_chk(`EFR_A_VEL, 32'h0000_0032);
        wr(`EFR_A_HYST, 32'h0);
        wr(`EFR_A_DVCLIP, 32'h0000_0007);
        set_slip(50, 6);
        rd_chk(`EFR_A_VEL, 32'h0000_0007);
        chk_w(regulated_velocity, 32'h0000_0007);
        set_slip(-50, 6);
        rd_chk(`EFR_A_VEL, 32'hffff_fff9);
        // Integrator: one error step per 128 cycles until the clip holds it.
        wr(`EFR_A_PGAIN, 32'h0);
        wr(`EFR_A_IGAIN, 32'h0000_0100);
        wr(`EFR_A_DVCLIP, 32'h7fff_ffff);
        wr(`EFR_A_ERR, 32'h0000_03e8);
        set_slip(10, 300);
        rd(`EFR_A_ISUM, isum_a);
        repeat (126) @(posedge ref_clk);
        rd(`EFR_A_ISUM, isum_b);
        chk_w(isum_b - isum_a, 32'h0000_000a);
        wr(`EFR_A_ERR, 32'h0000_001e);
        repeat (700) @(posedge ref_clk);
        rd_chk(`EFR_A_ISUM, 32'h0000_001e);
        rd_chk(`EFR_A_VEL, 32'h0000_001e);
        // Closed-loop angle, absolute encoder with a 16-cycle regulation period.
        wr(`EFR_A_BETA, 32'h0000_0008);
        wr(`EFR_A_HYST, 32'h0000_0002);
        wr(`EFR_A_CLGAIN, 32'h0001_0000);
        wr(`EFR_A_CYCLE, 32'h0010_0000);
        wr(`EFR_A_ENC_CFG, 32'h0000_0005);
        set_slip(4, 40);
        chk_w(commutation_angle, 32'h0000_03e8);
        c0 = cnt_lim;
        set_slip(20, 40);
        chk_w(commutation_angle, 32'h0000_03dc);
        chk_w(cnt_lim - c0, 1);
        wr(`EFR_A_CLGAIN, 32'h0000_8000);
        set_slip(6, 40);
        chk_w(commutation_angle, 32'h0000_03e5);
        set_slip(1, 40);
        chk_w(commutation_angle, 32'h0000_03e8);
        // Incremental encoder regulates every few cycles.
        wr(`EFR_A_ENC_CFG, 32'h0000_0001);
        set_slip(4, 12);
        chk_w(commutation_angle, 32'h0000_03e6);
        final_report();
    end
endmodule : test_encoder_feedback_regulator
